// >>> rtl/bbet_top.sv
// bbet_top: bit and block error tester with apb registers and test generator
// assumes an apb master on pclk; link pins are asynchronous to pclk
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bbet_top import bbet_pkg::*; #(
	parameter int BLK_BITS = 112 // data bits per block ahead of its crc
) (
	input  wire logic        pclk,                        // apb clock
	input  wire logic        presetn,                     // async reset, active low
	input  wire logic        psel,                        // apb select
	input  wire logic        penable,                     // apb access phase
	input  wire logic        pwrite,                      // apb write
	input  wire logic [7:0]  paddr,                       // apb byte address
	input  wire logic [31:0] pwdata,                      // apb write data
	output logic [31:0]      prdata,                      // apb read data
	output logic             pready,                      // apb ready
	output logic             pslverr,                     // apb error
	input  wire logic        link_clk,                    // clock from partner
	input  wire logic        link_data,                   // data from partner
	input  wire logic        data_gate_input,             // data gate pin
	input  wire logic        external_global_trigger_one, // single-run trigger pin
	input  wire logic        ext_restart_in,              // external restart pin
	output logic             tg_clk,                      // generator clock
	output logic             tg_data,                     // generator data
	output logic             tg_trig                      // generator gate or restart
);
	localparam logic [15:0] BLK_END = 16'(BLK_BITS - 1);
	localparam logic [15:0] BLK_LAST = 16'(BLK_BITS + 15);

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] mcnt;
		logic [31:0] merr;
		logic [31:0] tgfreq;
		logic [31:0] tgrate;
		logic [31:0] rdly;
		logic [31:0] gon;
		logic [31:0] goff;
		logic [31:0] prdata;
		logic        pslverr;
		logic [4:0]  s1;
		logic [4:0]  s2;
		logic [4:0]  s3;
		logic [4:0]  f;
		bbet_state_e st;
		logic        cont;
		logic        synced;
		logic [4:0]  scnt;
		logic [31:0] chk;
		logic [31:0] errs;
		logic [31:0] pv;
		logic [31:0] pe;
		logic [5:0]  run;
		logic [15:0] bpos;
		logic [15:0] crc;
		logic [15:0] rc;
	} bbet_top_s;

	localparam bbet_top_s RST = '{
		ctrl: CTRL_RST, mcnt: MCNT_RST, merr: MERR_RST, tgfreq: FREQ_RST,
		tgrate: RATE_RST, rdly: DUR_RST, gon: DUR_RST, goff: DUR_RST,
		st: ST_IDLE, crc: CRC_INIT, default: '0};

	bbet_top_s q;
	bbet_top_s n;

	logic        en, single, src_ext, xrst, blk, inv, crc_msb, tg_en, tg_rmode;
	logic [1:0]  gate;
	logic [1:0]  ign;
	logic [2:0]  ptype;
	logic        setup, acc_wr, st_rd;
	logic        cmd_start, cmd_stop, cmd_trig;
	logic [4:0]  pins;
	logic [4:0]  rise;
	logic        bit_in, gate_ok, sample, exp_bit, same, fb;
	logic        trig_go, xrst_go, limit, clr, evt;
	logic [15:0] rxc;
	logic        tg_step, tg_bit;

	assign en = q.ctrl[F_EN];
	assign single = q.ctrl[F_SINGLE];
	assign src_ext = q.ctrl[F_SRC_EXT];
	assign xrst = q.ctrl[F_XRST];
	assign blk = q.ctrl[F_BLK];
	assign inv = q.ctrl[F_INV];
	assign gate = q.ctrl[F_GATE +: 2];
	assign ign = q.ctrl[F_IGN +: 2];
	assign ptype = q.ctrl[F_PRBS +: 3];
	assign crc_msb = q.ctrl[F_CRC_MSB];
	assign tg_en = q.ctrl[F_TG_EN];
	assign tg_rmode = q.ctrl[F_TG_RST];

	assign setup = psel & ~penable;
	assign acc_wr = psel & penable & pwrite;
	assign st_rd = psel & penable & ~pwrite & (paddr == A_STAT);
	assign cmd_start = acc_wr & (paddr == A_CMD) & pwdata[C_START];
	assign cmd_stop = acc_wr & (paddr == A_CMD) & pwdata[C_STOP];
	assign cmd_trig = acc_wr & (paddr == A_CMD) & pwdata[C_TRIG];
	// no wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr & psel & penable;

	assign pins = {ext_restart_in, external_global_trigger_one, data_gate_input,
		link_data, link_clk};

	always_comb begin
		n = q;
		clr = 1'b0;
		rxc = '0;
		fb = 1'b0;
		// three-stage sync, level taken once stages two and three agree
		n.s1 = pins;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.f = (q.s2 & q.s3) | (q.f & (q.s2 ^ q.s3));
		rise = n.f & ~q.f;
		bit_in = q.f[1] ^ inv;
		gate_ok = (gate == GATE_OFF) | ((gate == GATE_HIGH) & q.f[2])
			| ((gate == GATE_LOW) & ~q.f[2]);
		sample = rise[0] & gate_ok & (q.st == ST_RUN);
		trig_go = single & (src_ext ? rise[3] : cmd_trig);
		xrst_go = xrst & rise[4] & (q.st != ST_IDLE);
		limit = (q.chk >= q.mcnt) | (q.errs >= q.merr);
		evt = ~en | cmd_stop | cmd_start | trig_go | xrst_go;
		same = ((ign == IGN_ZERO) & ~bit_in) | ((ign == IGN_ONE) & bit_in);

		if (acc_wr) begin
			case (paddr)
				A_CTRL: n.ctrl = pwdata;
				A_MCNT: n.mcnt = pwdata;
				A_MERR: n.merr = pwdata;
				A_TGFREQ: n.tgfreq = pwdata;
				A_TGRATE: n.tgrate = pwdata;
				A_RDLY: n.rdly = pwdata;
				A_GON: n.gon = pwdata;
				A_GOFF: n.goff = pwdata;
				default: n.ctrl = q.ctrl;
			endcase
		end
		if (setup) begin
			n.pslverr = 1'b0;
			case (paddr)
				A_CTRL: n.prdata = q.ctrl;
				A_CMD: n.prdata = '0;
				A_MCNT: n.prdata = q.mcnt;
				A_MERR: n.prdata = q.merr;
				A_CHK: n.prdata = q.chk;
				A_ERRS: n.prdata = q.errs;
				A_STAT: n.prdata = {28'h000_0000, q.synced, q.cont, q.st == ST_RUN, q.st[1]};
				A_TGFREQ: n.prdata = q.tgfreq;
				A_TGRATE: n.prdata = q.tgrate;
				A_RDLY: n.prdata = q.rdly;
				A_GON: n.prdata = q.gon;
				A_GOFF: n.prdata = q.goff;
				default: begin
					n.prdata = '0;
					n.pslverr = 1'b1;
				end
			endcase
		end

		if (!en) begin
			n.st = ST_IDLE;
		end else if (cmd_stop) begin
			if (q.st != ST_IDLE) begin
				n.st = ST_DONE;
			end
		end else if (cmd_start) begin
			clr = 1'b1;
			n.st = ST_RUN;
			n.cont = 1'b1;
		end else if (trig_go) begin
			clr = 1'b1;
			n.st = ST_RUN;
			n.cont = 1'b0;
		end else if (xrst_go) begin
			clr = 1'b1;
			n.st = ST_RUN;
		end else if (q.st == ST_RUN && limit) begin
			n.st = q.cont ? ST_HOLD : ST_DONE;
		end else if (q.st == ST_HOLD && st_rd) begin
			clr = 1'b1;
			n.st = ST_RUN;
		end

		if (sample && blk) begin
			if (q.bpos <= BLK_END) begin
				fb = q.crc[15] ^ bit_in;
				n.crc = {q.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			end else begin
				n.rc = {q.rc[14:0], bit_in};
			end
			n.bpos = q.bpos + 16'h0001;
			if (q.bpos == BLK_LAST) begin
				rxc = crc_msb ? n.rc : {n.rc[7:0], n.rc[15:8]};
				n.chk = q.chk + 32'h0000_0001;
				n.errs = q.errs + {31'h0, rxc != q.crc};
				n.bpos = '0;
				n.crc = CRC_INIT;
			end
		end else if (sample && !q.synced) begin
			// reference loads received bits until it can predict them
			n.scnt = q.scnt + 5'h01;
			n.synced = (q.scnt == SYNC_BITS - 5'h01);
		end else if (sample) begin
			// results pass a 32-bit delay so a long run can be struck out whole
			n.run = same ? ((q.run == IGN_RUN) ? q.run : q.run + 6'h01) : 6'h00;
			n.pv = {q.pv[30:0], 1'b1};
			n.pe = {q.pe[30:0], bit_in ^ exp_bit};
			if (n.run == IGN_RUN) begin
				n.pv = '0;
			end
			n.chk = q.chk + {31'h0, q.pv[31]};
			n.errs = q.errs + {31'h0, q.pv[31] & q.pe[31]};
		end

		if (clr) begin
			n.chk = '0;
			n.errs = '0;
			n.synced = 1'b0;
			n.scnt = '0;
			n.pv = '0;
			n.pe = '0;
			n.run = '0;
			n.bpos = '0;
			n.crc = CRC_INIT;
			n.rc = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	bbet_prbs u_ref (
		.pclk    (pclk),
		.presetn (presetn),
		.step    (sample & ~blk),
		.load    (~q.synced),
		.din     (bit_in),
		.ptype   (ptype),
		.exp_bit (exp_bit)
	);

	bbet_prbs u_tg_prbs (
		.pclk    (pclk),
		.presetn (presetn),
		.step    (tg_step),
		.load    (1'b0),
		.din     (1'b0),
		.ptype   (ptype),
		.exp_bit (tg_bit)
	);

	bbet_testgen u_tg (
		.pclk     (pclk),
		.presetn  (presetn),
		.en       (tg_en),
		.rst_mode (tg_rmode),
		.freq     (q.tgfreq),
		.rate     (q.tgrate),
		.restart_delay   (q.rdly),
		.on_time  (q.gon),
		.off_time (q.goff),
		.prbs_bit (tg_bit),
		.step     (tg_step),
		.tg_clk   (tg_clk),
		.tg_data  (tg_data),
		.tg_trig  (tg_trig)
	);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_count_end: assert property (q.st == ST_RUN && q.chk >= q.mcnt && !evt |=> q.st[1])
		else $error("check count limit did not end the run");
	a_gate_skip: assert property (!gate_ok && !clr |=> $stable(q.chk) && $stable(q.errs))
		else $error("gated data changed the counts");
	a_hold_read: assert property (q.st == ST_HOLD && !st_rd && !evt |=> q.st == ST_HOLD)
		else $error("continuous run restarted before results were read");
	a_err_end: assert property (q.st == ST_RUN && q.errs >= q.merr && !evt |=> q.st[1])
		else $error("error limit did not end the run");
	a_xrst_off: assert property (q.st == ST_DONE && !xrst && !evt |=> q.st == ST_DONE)
		else $error("restart while external restart disabled");
	a_start_cont: assert property (en && cmd_start && !cmd_stop
		|=> q.st == ST_RUN && q.cont && q.chk == 32'h0 ##1 q.st != ST_IDLE || !en)
		else $error("start did not launch a continuous run");
	a_stop_halt: assert property (en && cmd_stop && q.st != ST_IDLE |=> q.st == ST_DONE)
		else $error("stop did not halt the measurement");
	a_trig_one: assert property (en && trig_go && !cmd_stop && !cmd_start
		|=> q.st == ST_RUN && !q.cont)
		else $error("trigger did not launch a single run");
	a_sync_bits: assert property (sample && !blk && !q.synced
		&& q.scnt == SYNC_BITS - 5'h01 && !clr |=> q.synced)
		else $error("reference not synchronised after loading");
endmodule
`default_nettype wire

// >>> rtl/bbet_pkg.sv
// bbet_pkg: register map, control field positions, reset values, codes
// assumes a 100 MHz pclk and a 32-bit apb master
package bbet_pkg;
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_CMD    = 8'h04;
	localparam logic [7:0] A_MCNT   = 8'h08;
	localparam logic [7:0] A_MERR   = 8'h0c;
	localparam logic [7:0] A_CHK    = 8'h10;
	localparam logic [7:0] A_ERRS   = 8'h14;
	localparam logic [7:0] A_STAT   = 8'h18;
	localparam logic [7:0] A_TGFREQ = 8'h1c;
	localparam logic [7:0] A_TGRATE = 8'h20;
	localparam logic [7:0] A_RDLY   = 8'h24;
	localparam logic [7:0] A_GON    = 8'h28;
	localparam logic [7:0] A_GOFF   = 8'h2c;

	localparam int F_EN = 0, F_SINGLE = 1, F_SRC_EXT = 2, F_XRST = 3, F_BLK = 4, F_INV = 5;
	localparam int F_GATE = 6, F_IGN = 8, F_PRBS = 10, F_CRC_MSB = 13, F_TG_EN = 14;
	localparam int F_TG_RST = 15;
	localparam int C_START = 0, C_STOP = 1, C_TRIG = 2;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0080;
	localparam logic [31:0] MCNT_RST  = 32'h0001_86a0;
	localparam logic [31:0] MERR_RST  = 32'h0000_0064;
	localparam logic [31:0] FREQ_RST  = 32'h000f_4240;
	localparam logic [31:0] RATE_RST  = 32'h0000_0000;
	localparam logic [31:0] DUR_RST   = 32'h0000_03e8;
	localparam logic [31:0] CLK_HZ    = 32'h05f5_e100;
	localparam logic [31:0] FREQ_HALF = 32'h02fa_f080;

	localparam logic [1:0] GATE_OFF = 2'h0, GATE_HIGH = 2'h1, GATE_LOW = 2'h2;
	localparam logic [1:0] IGN_OFF = 2'h0, IGN_ZERO = 2'h1, IGN_ONE = 2'h2;
	localparam logic [2:0] PRBS9 = 3'h0, PRBS11 = 3'h1, PRBS15 = 3'h2, PRBS16 = 3'h3;
	localparam logic [2:0] PRBS20 = 3'h4, PRBS21 = 3'h5, PRBS23 = 3'h6;
	localparam logic [4:0] SYNC_BITS = 5'h18;
	localparam logic [5:0] IGN_RUN = 6'h20;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [22:0] PRBS_SEED = 23'h00_0001;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b11,
		ST_DONE = 2'b10
	} bbet_state_e;
endpackage

// >>> rtl/bbet_prbs.sv
// bbet_prbs: selectable fibonacci prbs with self-synchronising load
// assumes step is a one-cycle pulse per bit from the same clock
`timescale 1ns/10ps
`default_nettype none
module bbet_prbs import bbet_pkg::*; (
	input  wire logic       pclk,    // clock
	input  wire logic       presetn, // async reset, active low
	input  wire logic       step,    // advance one bit
	input  wire logic       load,    // shift din in instead of own bit
	input  wire logic       din,     // received bit for loading
	input  wire logic [2:0] ptype,   // sequence order select
	output logic            exp_bit  // next bit of the sequence
);
	typedef struct packed {
		logic [22:0] h;
	} bbet_prbs_s;
	bbet_prbs_s q;
	bbet_prbs_s n;

	always_comb begin
		n = q;
		case (ptype)
			PRBS11: exp_bit = q.h[10] ^ q.h[8];
			PRBS15: exp_bit = q.h[14] ^ q.h[13];
			PRBS16: exp_bit = q.h[15] ^ q.h[13] ^ q.h[12] ^ q.h[10];
			PRBS20: exp_bit = q.h[19] ^ q.h[2];
			PRBS21: exp_bit = q.h[20] ^ q.h[18];
			PRBS23: exp_bit = q.h[22] ^ q.h[17];
			default: exp_bit = q.h[8] ^ q.h[4];
		endcase
		if (step) begin
			n.h = {q.h[21:0], load ? din : exp_bit};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{h: PRBS_SEED};
		end else begin
			q <= n;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/bbet_testgen.sv
// bbet_testgen: self-test source of clock, data, gate window, restart pulse
// assumes prbs_bit comes from a bbet_prbs stepped by step
`timescale 1ns/10ps
`default_nettype none
module bbet_testgen import bbet_pkg::*; (
	input  wire logic        pclk,     // clock
	input  wire logic        presetn,  // async reset, active low
	input  wire logic        en,       // generator on
	input  wire logic        rst_mode, // trigger out is restart pulse
	input  wire logic [31:0] freq,     // bit clock in hz
	input  wire logic [31:0] rate,     // error threshold, fraction of 2^32
	input  wire logic [31:0] restart_delay,   // bits before restart pulse
	input  wire logic [31:0] on_time,  // gate active bits
	input  wire logic [31:0] off_time, // gate inactive bits
	input  wire logic        prbs_bit, // next reference bit
	output logic             step,     // advance prbs
	output logic             tg_clk,   // generated bit clock
	output logic             tg_data,  // generated data
	output logic             tg_trig   // gate window or restart pulse
);
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] cnt;
		logic [31:0] rnd;
		logic        clk;
		logic        data;
		logic        trig;
		logic        ph_on;
		logic        fired;
	} bbet_tg_s;
	localparam bbet_tg_s RST = '{rnd: 32'h0000_0001, ph_on: 1'b1, default: '0};
	bbet_tg_s q;
	bbet_tg_s n;
	logic [31:0] inc;
	logic [31:0] sum;
	logic [31:0] len;

	always_comb begin
		n = q;
		step = 1'b0;
		// above half the pclk rate the clock toggles every cycle
		inc = (freq > FREQ_HALF) ? CLK_HZ : {freq[30:0], 1'b0};
		sum = q.acc + inc;
		len = q.ph_on ? on_time : off_time;
		if (!en) begin
			n = RST;
		end else if (sum >= CLK_HZ) begin
			n.acc = sum - CLK_HZ;
			n.clk = ~q.clk;
			if (q.clk) begin
				// data moves on the falling edge, stable at the rising one
				step = 1'b1;
				n.rnd = {q.rnd[30:0], q.rnd[31] ^ q.rnd[21] ^ q.rnd[1] ^ q.rnd[0]};
				n.data = prbs_bit ^ (q.rnd < rate);
				n.cnt = q.cnt + 32'h0000_0001;
				if (rst_mode) begin
					n.trig = !q.fired && q.cnt == restart_delay;
					n.fired = q.fired | n.trig;
				end else begin
					n.trig = q.ph_on;
					if (n.cnt >= len) begin
						n.ph_on = ~q.ph_on;
						n.cnt = '0;
					end
				end
			end
		end else begin
			n.acc = sum;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	assign tg_clk = q.clk;
	assign tg_data = q.data;
	assign tg_trig = q.trig;

	a_tg_off: assert property (@(posedge pclk) disable iff (!presetn)
		!en |=> !tg_clk && !tg_trig && !tg_data)
		else $error("test generator active while off");
endmodule
`default_nettype wire

// >>> bench/bbet_link_model.sv
// bbet_link_model: far-side device sending clocked prbs9 data with a gate level
// assumes the tester samples data on the rising link clock; clock halts between frames
`timescale 1ns/10ps
`default_nettype none
module bbet_link_model import bbet_pkg::*; (
	output logic link_clk,  // bit clock, still outside frames
	output logic link_data, // bit data
	output logic gate       // data gate level
);
	logic [8:0] hist;
	initial begin
		link_clk = 1'b0;
		link_data = 1'b0;
		gate = 1'b0;
		hist = 9'h1ff;
	end
	// one bit period; clock stays low once it returns
	task automatic clk_bit(input logic b);
		link_data = b;
		#31.25 link_clk = 1'b1; // data settled well before the rise
		#62.5 link_clk = 1'b0;
		#31.25;
	endtask

	// next bit of the shared prbs9 history
	task automatic next_bit(output logic b);
		b = hist[8] ^ hist[4];
		hist = {hist[7:0], b};
	endtask

	// n bits at gate level g; ok=0 sends filler, e flips every e-th bit, inv inverts
	task automatic send(input int n, input logic g, input logic ok, input int e, input logic inv);
		logic b;
		for (int i = 1; i <= n; i++) begin
			if (ok)
				next_bit(b);
			else
				b = ~link_data; // filler toggles when inv is 0; with inv set it holds one steady level
			if (e != 0 && i % e == 0)
				b = ~b;
			gate = g;
			clk_bit(b ^ inv);
		end
	endtask

	// n bits of one steady level, history left alone
	task automatic steady(input int n, input logic v);
		for (int i = 0; i < n; i++)
			clk_bit(v);
	endtask

	// nb prbs bits and their crc, low byte first unless msb; bad spoils the crc
	task automatic block(input int nb, input logic msb, input logic bad);
		logic        b;
		logic [15:0] c;
		logic [15:0] t;
		c = CRC_INIT;
		for (int i = 0; i < nb; i++) begin
			next_bit(b);
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
			clk_bit(b);
		end
		t = msb ? c : {c[7:0], c[15:8]};
		t[0] = t[0] ^ bad;
		for (int i = 15; i >= 0; i--)
			clk_bit(t[i]);
	endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: apb-driven bench for the bit and block error tester
// assumes bbet_link_model as far side and the register map of bbet_pkg
`timescale 1ns/10ps
`default_nettype none
module tb_top import bbet_pkg::*; ();
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        link_clk, link_data, gate, egt, xrst_in, tg_clk, tg_data, tg_trig;
	logic        loop, lclk, ldat;
	int          failures, comparisons, cyc;
	logic [7:0]  ra [10] = '{A_CTRL, A_CMD, A_MCNT, A_MERR, A_TGFREQ, A_TGRATE, A_RDLY,
		A_GON, A_GOFF, A_STAT};
	logic [31:0] rv [10] = '{32'h80, 32'h0, 32'h186a0, 32'h64, 32'hf4240, 32'h0, 32'h3e8,
		32'h3e8, 32'h3e8, 32'h0};

	bbet_top bbet_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(lclk), .link_data(ldat),
		.data_gate_input(gate), .external_global_trigger_one(egt),
		.ext_restart_in(xrst_in), .tg_clk(tg_clk), .tg_data(tg_data), .tg_trig(tg_trig));
	bbet_link_model bbet_link_model_i (.link_clk(link_clk), .link_data(link_data), .gate(gate));

	// self-test loops the generator clock and data pins back into the link inputs
	assign lclk = loop ? tg_clk : link_clk;
	assign ldat = loop ? tg_data : link_data;

	always #5 pclk = ~pclk;

	task automatic end_sim;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard, well above the few thousand bit times used
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(r & m, exp);
	endtask

	// lets the last bit clear the input synchroniser
	task automatic settle;
		repeat (20) @(posedge pclk);
	endtask

	// 40-bit single run: 24 sync + 32 delay + 40 counted, a few spare
	task automatic single_run(input logic [31:0] ctrl, input logic inv);
		wr(A_MCNT, 32'd40);
		wr(A_CTRL, ctrl);
		wr(A_CMD, 32'h4);
		bbet_link_model_i.send(100, 1'b0, 1'b1, 0, inv);
		settle();
	endtask

	initial begin
		logic [31:0] c1;
		int          n;
		int          m;
		logic        p;
		logic        pt;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		egt = 1'b0;
		xrst_in = 1'b0;
		loop = 1'b0;
		failures = 0;
		comparisons = 0;
		cyc = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++)
			rdm(ra[i], 32'hffffffff, rv[i]);
		rdm(8'h40, 32'hffffffff, 32'h0);
		chk(perr, 1'b1);
		single_run(32'h03, 1'b0);
		rdm(A_CHK, 32'hffffffff, 32'd40);
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		rdm(A_STAT, 32'h3, 32'h1);
		wr(A_MCNT, 32'd1000);
		wr(A_MERR, 32'd3);
		wr(A_CMD, 32'h4);
		bbet_link_model_i.send(200, 1'b0, 1'b1, 30, 1'b0);
		settle();
		rdm(A_ERRS, 32'hffffffff, 32'd3);
		rdm(A_STAT, 32'h3, 32'h1);
		wr(A_MERR, 32'd100);
		wr(A_MCNT, 32'd40);
		wr(A_CTRL, 32'h43);
		wr(A_CMD, 32'h4);
		for (int i = 0; i < 10; i++) begin
			bbet_link_model_i.send(10, 1'b1, 1'b1, 0, 1'b0);
			bbet_link_model_i.send(5, 1'b0, 1'b0, 0, 1'b0);
		end
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd40);
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		single_run(32'h23, 1'b1);
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		wr(A_CTRL, 32'h01);
		wr(A_CMD, 32'h1);
		bbet_link_model_i.send(100, 1'b0, 1'b1, 0, 1'b0);
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd40);
		bbet_link_model_i.send(50, 1'b0, 1'b1, 0, 1'b0);
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd40);
		rdm(A_STAT, 32'h9, 32'h9);
		bbet_link_model_i.send(100, 1'b0, 1'b1, 0, 1'b0);
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd40);
		rdm(A_STAT, 32'h9, 32'h9);
		bbet_link_model_i.send(70, 1'b0, 1'b1, 0, 1'b0);
		wr(A_CMD, 32'h2);
		rdm(A_STAT, 32'h2, 32'h0);
		apb(1'b0, A_CHK, 32'h0, c1);
		chk(c1, 32'd14); // 70 bits: 24 sync, 46 samples, 32 in the delay
		bbet_link_model_i.send(60, 1'b0, 1'b1, 0, 1'b0);
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd14);
		wr(A_CTRL, 32'h07);
		rdm(A_STAT, 32'h2, 32'h0);
		egt <= 1'b1;
		settle();
		egt <= 1'b0;
		rdm(A_STAT, 32'h2, 32'h2);
		single_run(32'h0b, 1'b0);
		rdm(A_CHK, 32'hffffffff, 32'd40);
		xrst_in <= 1'b1;
		settle();
		xrst_in <= 1'b0;
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd0);
		rdm(A_STAT, 32'h2, 32'h2);
		// a run of 40 ones is struck whole; what is left is at most 36 clean bits
		wr(A_CTRL, 32'h203);
		wr(A_CMD, 32'h4);
		bbet_link_model_i.send(60, 1'b0, 1'b1, 0, 1'b0);
		bbet_link_model_i.steady(40, 1'b1);
		settle();
		apb(1'b0, A_CHK, 32'h0, c1);
		chk(c1 >= 32'd27 && c1 <= 32'd36, 1'b1);
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		wr(A_MCNT, 32'd2);
		wr(A_CTRL, 32'h13);
		wr(A_CMD, 32'h4);
		bbet_link_model_i.block(112, 1'b0, 1'b0);
		bbet_link_model_i.block(112, 1'b0, 1'b1);
		settle();
		rdm(A_CHK, 32'hffffffff, 32'd2);
		rdm(A_ERRS, 32'hffffffff, 32'd1);
		wr(A_MCNT, 32'd1);
		wr(A_CTRL, 32'h2013);
		wr(A_CMD, 32'h4);
		bbet_link_model_i.block(112, 1'b1, 1'b0);
		settle();
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		rdm(A_STAT, 32'h3, 32'h1);
		wr(A_CMD, 32'h2);
		wr(A_TGFREQ, 32'd10000000);
		wr(A_GON, 32'd10);
		wr(A_GOFF, 32'd10);
		for (int s = 0; s < 2; s++) begin
			n = 0;
			m = 0;
			p = tg_clk;
			pt = tg_trig;
			repeat (1000) begin
				@(negedge pclk);
				if (tg_clk === 1'b1 && p === 1'b0)
					n++;
				if (tg_trig === 1'b1 && pt === 1'b0)
					m++;
				p = tg_clk;
				pt = tg_trig;
			end
			if (s == 0) begin
				chk(n, 0);
				chk(m, 0);
			end else begin
				chk(n >= 99 && n <= 101, 1'b1);
				chk(m >= 4 && m <= 6, 1'b1);
			end
			wr(A_CTRL, 32'h4000);
		end
		// self-test: the tester measures the generator's own stream
		loop <= 1'b1;
		wr(A_MCNT, 32'd40);
		wr(A_CTRL, 32'h4003);
		wr(A_CMD, 32'h4);
		repeat (1200) @(posedge pclk);
		rdm(A_CHK, 32'hffffffff, 32'd40);
		rdm(A_ERRS, 32'hffffffff, 32'd0);
		wr(A_TGRATE, 32'h8000_0000);
		wr(A_MERR, 32'd3);
		wr(A_CMD, 32'h4);
		repeat (1500) @(posedge pclk);
		rdm(A_ERRS, 32'hffffffff, 32'd3);
		rdm(A_STAT, 32'h3, 32'h1);
		end_sim();
	end
endmodule
`default_nettype wire
